// ==== src/flash_id_host.sv ====
// Host controller that drives the flash pins for reads, writes, identification and protection.
module flash_id_host (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [19:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic [1:0] cmdSel,
  input wire logic [4:0] cmdSector,
  input wire logic cmdHv,
  output logic cmdReady,
  output logic rspValid,
  output logic rspErr,
  output logic [7:0] rspData,
  output logic idMode,
  output logic [18:0] protMask,
  output logic [19:0] addrPins,
  output logic ceN,
  output logic oeN,
  output logic weN,
  output logic [7:0] dataPinsOut,
  output logic dataPinsOe,
  input wire logic [7:0] dataPinsIn,
  output logic addressBitNineVid,
  output logic resetPinVid
);

  typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_NEXT} state_t;

  state_t state_q, state_d;
  flash_host_pkg::op_t curOp_q, curOp_d;
  flash_host_pkg::idsel_t sel_q, sel_d;
  logic [4:0] sector_q, sector_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] step_q, step_d;
  logic [1:0] lastStep_q, lastStep_d;
  logic isWrite_q, isWrite_d;
  logic cmdReady_q, cmdReady_d;
  logic rspValid_q, rspValid_d;
  logic rspErr_q, rspErr_d;
  logic [7:0] rspData_q, rspData_d;
  logic idMode_q, idMode_d;
  logic [18:0] protMask_q, protMask_d;
  logic [19:0] addr_q, addr_d;
  logic ceN_q, ceN_d;
  logic oeN_q, oeN_d;
  logic weN_q, weN_d;
  logic [7:0] dqOut_q, dqOut_d;
  logic dqOe_q, dqOe_d;
  logic a9Vid_q, a9Vid_d;
  logic resetVid_q, resetVid_d;
  logic [7:0] dqSync;

  pin_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinIn(dataPinsIn),
    .pinSync(dqSync)
  );

  // Address and data of one step of the identification unlock sequence.
  function automatic logic [27:0] unlockStep(input logic [1:0] step);
    unique case (step)
      2'h0: unlockStep = {flash_host_pkg::UNLOCK_ADDR0, flash_host_pkg::UNLOCK_DATA0};
      2'h1: unlockStep = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::UNLOCK_DATA1};
      default: unlockStep = {flash_host_pkg::UNLOCK_ADDR0, flash_host_pkg::AUTOSEL_CMD};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    flash_host_pkg::op_t op;
    logic refuse;
    op = flash_host_pkg::op_t'(cmdOp);
    refuse = 1'b0;
    state_d = state_q;
    curOp_d = curOp_q;
    sel_d = sel_q;
    sector_d = sector_q;
    cnt_d = cnt_q;
    step_d = step_q;
    lastStep_d = lastStep_q;
    isWrite_d = isWrite_q;
    cmdReady_d = 1'b0;
    rspValid_d = 1'b0;
    rspErr_d = rspErr_q;
    rspData_d = rspData_q;
    idMode_d = idMode_q;
    protMask_d = protMask_q;
    addr_d = addr_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    dqOut_d = dqOut_q;
    dqOe_d = dqOe_q;
    a9Vid_d = a9Vid_q;
    resetVid_d = resetVid_q;
    unique case (state_q)
      // (RL11) Power-up hold-off
      ST_POWERUP: begin
        if (cnt_q == 8'h00) begin
          state_d = ST_IDLE;
          cmdReady_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_IDLE: begin
        cmdReady_d = 1'b1;
        if (cmdValid && cmdReady_q) begin
          cmdReady_d = 1'b0;
          // (RL19) Reset before array reads
          refuse = (op == flash_host_pkg::OP_READ) && idMode_q;
          refuse = refuse || ((op == flash_host_pkg::OP_IDREAD) && !cmdHv && !idMode_q);
          refuse = refuse || ((op == flash_host_pkg::OP_IDREAD) && (cmdSel == 2'(flash_host_pkg::SEL_PROT))
                              && (cmdSector >= 5'(flash_host_pkg::NUM_SECTORS)));
          // (RL7) All protected first
          refuse = refuse || ((op == flash_host_pkg::OP_UNPROT_WR) && !((&protMask_q) && resetVid_q));
          curOp_d = op;
          sel_d = flash_host_pkg::idsel_t'(cmdSel);
          sector_d = cmdSector;
          if (refuse) begin
            rspValid_d = 1'b1;
            rspErr_d = 1'b1;
          end else if (op == flash_host_pkg::OP_VID_ON || op == flash_host_pkg::OP_VID_OFF) begin
            // (RL6) Reset-pin elevated level
            resetVid_d = (op == flash_host_pkg::OP_VID_ON);
            rspValid_d = 1'b1;
            rspErr_d = 1'b0;
          end else begin
            isWrite_d = (op != flash_host_pkg::OP_READ) && (op != flash_host_pkg::OP_IDREAD);
            step_d = 2'h0;
            lastStep_d = (op == flash_host_pkg::OP_AUTOSEL) ? flash_host_pkg::AUTOSEL_LAST_STEP : 2'h0;
            addr_d = cmdAddr;
            dqOut_d = (op == flash_host_pkg::OP_RESET) ? flash_host_pkg::RESET_CMD : cmdData;
            if (op == flash_host_pkg::OP_AUTOSEL) begin
              // (RL4) In-system unlock sequence
              {addr_d, dqOut_d} = unlockStep(2'h0);
            end
            if (op == flash_host_pkg::OP_IDREAD) begin
              // (RL2) Select lines and offset
              addr_d = {cmdAddr[19:8], 6'h00, cmdSel};
              // (RL1) Elevated level on bit nine
              a9Vid_d = cmdHv;
            end
            ceN_d = 1'b0;
            dqOe_d = isWrite_d;
            state_d = ST_SETUP;
          end
        end
      end
      // (RL15) Address settled before strobe
      ST_SETUP: begin
        state_d = ST_STROBE;
        if (isWrite_q) begin
          // (RL10) Write with output-enable high
          weN_d = 1'b0;
          cnt_d = 8'(flash_host_pkg::WR_CYC - 1);
        end else begin
          oeN_d = 1'b0;
          cnt_d = 8'(flash_host_pkg::RD_CYC - 1);
        end
      end
      ST_STROBE: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          state_d = ST_RECOVER;
          if (isWrite_q) begin
            // (RL16) Write-enable rises first
            weN_d = 1'b1;
          end else begin
            oeN_d = 1'b1;
            rspData_d = dqSync;
          end
        end
      end
      ST_RECOVER: begin
        ceN_d = 1'b1;
        dqOe_d = 1'b0;
        a9Vid_d = 1'b0;
        if (step_q != lastStep_q) begin
          step_d = step_q + 2'h1;
          state_d = ST_NEXT;
        end else begin
          rspValid_d = 1'b1;
          rspErr_d = 1'b0;
          cmdReady_d = 1'b1;
          state_d = ST_IDLE;
          if (curOp_q == flash_host_pkg::OP_AUTOSEL) begin
            idMode_d = 1'b1;
          end
          // (RL21) Reset leaves identification
          if (curOp_q == flash_host_pkg::OP_RESET) begin
            idMode_d = 1'b0;
          end
          // (RL3) Record protection answer
          if (curOp_q == flash_host_pkg::OP_IDREAD && sel_q == flash_host_pkg::SEL_PROT) begin
            protMask_d[sector_q] = (rspData_q == flash_host_pkg::PROT_YES);
          end
        end
      end
      ST_NEXT: begin
        {addr_d, dqOut_d} = unlockStep(step_q);
        ceN_d = 1'b0;
        dqOe_d = 1'b1;
        state_d = ST_SETUP;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_POWERUP;
      curOp_q <= flash_host_pkg::OP_READ;
      sel_q <= flash_host_pkg::SEL_MAKER;
      sector_q <= 5'h00;
      cnt_q <= 8'(flash_host_pkg::PWRUP_CYC - 1);
      step_q <= 2'h0;
      lastStep_q <= 2'h0;
      isWrite_q <= 1'b0;
      cmdReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspErr_q <= 1'b0;
      rspData_q <= 8'h00;
      // (RL12) Array reads after reset
      idMode_q <= 1'b0;
      // (RL8) Unprotected as delivered
      protMask_q <= 19'h00000;
      addr_q <= 20'h00000;
      ceN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      dqOut_q <= 8'h00;
      dqOe_q <= 1'b0;
      a9Vid_q <= 1'b0;
      resetVid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      curOp_q <= curOp_d;
      sel_q <= sel_d;
      sector_q <= sector_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      lastStep_q <= lastStep_d;
      isWrite_q <= isWrite_d;
      cmdReady_q <= cmdReady_d;
      rspValid_q <= rspValid_d;
      rspErr_q <= rspErr_d;
      rspData_q <= rspData_d;
      idMode_q <= idMode_d;
      protMask_q <= protMask_d;
      addr_q <= addr_d;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      dqOut_q <= dqOut_d;
      dqOe_q <= dqOe_d;
      a9Vid_q <= a9Vid_d;
      resetVid_q <= resetVid_d;
    end
  end

  assign cmdReady = cmdReady_q;
  assign rspValid = rspValid_q;
  assign rspErr = rspErr_q;
  assign rspData = rspData_q;
  assign idMode = idMode_q;
  assign protMask = protMask_q;
  assign addrPins = addr_q;
  assign ceN = ceN_q;
  assign oeN = oeN_q;
  assign weN = weN_q;
  assign dataPinsOut = dqOut_q;
  assign dataPinsOe = dqOe_q;
  assign addressBitNineVid = a9Vid_q;
  assign resetPinVid = resetVid_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_WRITE_QUALIFIED: assert property (!weN_q |-> !ceN_q && oeN_q) // (RL10)
    else $error("Write strobe without chip-enable low and output-enable high.");
  AST_PULSE_WIDTH: assert property ($fell(weN_q) |-> !weN_q[*4]) // (RL9)
    else $error("Write-enable pulse shorter than four cycles.");
  AST_ADDR_STABLE: assert property (!ceN_q && $past(!ceN_q) && $past(state_q) != ST_IDLE
                                    |-> $stable(addr_q)) // (RL15)
    else $error("Address moved while chip-enable was low.");
  AST_DATA_HELD: assert property ($rose(weN_q) |-> !ceN_q && dqOe_q && $stable(dqOut_q)) // (RL16)
    else $error("Data not held at the write-enable rise.");
  AST_POWERUP_QUIET: assert property (state_q == ST_POWERUP |-> weN_q && ceN_q) // (RL11)
    else $error("Strobe driven during power-up hold-off.");
  AST_ID_SELECT: assert property (a9Vid_q && !oeN_q |-> !addr_q[flash_host_pkg::BIT_SIX]) // (RL2)
    else $error("Bit six high during elevated identification read.");
  AST_VID_ONLY_ID: assert property (a9Vid_q |-> curOp_q == flash_host_pkg::OP_IDREAD && !ceN_q) // (RL1)
    else $error("Elevated level on bit nine outside an identification read.");
  AST_NO_READ_IN_ID: assert property (!oeN_q && curOp_q == flash_host_pkg::OP_READ |-> !idMode_q) // (RL19)
    else $error("Array read while identification mode is active.");
  AST_UNPROT_GUARD: assert property (!weN_q && curOp_q == flash_host_pkg::OP_UNPROT_WR
                                     |-> (&protMask_q) && resetVid_q) // (RL7)
    else $error("Unprotect cycle before every sector was protected.");
  AST_PROT_RECORD: assert property (rspValid_q && !rspErr_q && curOp_q == flash_host_pkg::OP_IDREAD
                                    && sel_q == flash_host_pkg::SEL_PROT
                                    |-> protMask_q[sector_q] == (rspData_q == flash_host_pkg::PROT_YES)) // (RL3)
    else $error("Protection answer not recorded for the queried sector.");

  COV_AUTOSEL: cover property (rspValid_q && curOp_q == flash_host_pkg::OP_AUTOSEL);
  COV_HV_READ: cover property ($fell(oeN_q) && a9Vid_q);
  COV_REFUSED: cover property (rspValid_q && rspErr_q);
  COV_UNPROT: cover property ($fell(weN_q) && curOp_q == flash_host_pkg::OP_UNPROT_WR);

endmodule // flash_id_host

// ==== src/flash_host_pkg.sv ====
// Constants and types shared by the host controller for the boot-sector flash command front.
// Overview of operation
// (RL1) Elevated-voltage identification only while address bit nine is held at the ID level.
// (RL2) With address bit six low, bits one and zero select the identification byte.
// (RL3) Protection query puts sector on high address bits; answer 01h protected, 00h not.
// (RL4) Identification codes also reachable in-system through an unlock command sequence.
// (RL5) The flash refuses program and erase to any protected sector.
// (RL6) Protect and unprotect use the elevated level on the reset pin with bus cycles.
// (RL7) Every sector must be protected before the first unprotect write cycle.
// (RL8) All sectors start out unprotected.
// (RL9) Strobe pulses below about 5 ns must not start a write.
// (RL10) A write needs chip-enable and write-enable low with output-enable high.
// (RL11) No command is taken on a write-enable rise during power-up.
// (RL12) After power-up the flash reads its array with no command.
// (RL13) Elevated reset level temporarily unprotects; removing it restores protection.
// (RL14) Wrong address, data or order makes the flash return to array reads.
// (RL15) Address is captured on the later falling edge of write-enable or chip-enable.
// (RL16) Data is captured on the earlier rising edge of write-enable or chip-enable.
// (RL17) After program or erase completes the flash returns to array reads.
// (RL18) In erase-suspend, reads of the suspended sector return status, others array data.
// (RL19) Identification mode or time-limit status needs the reset command to leave.
// (RL20) In-system ID offsets: maker 00h, part 01h, continuation 03h, protection 02h.
// (RL21) The reset command ignores address bits and returns the flash to array reads.
// (RL22) During identification reads the flash drives the selected byte on the data pins.
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_AUTOSEL, OP_IDREAD, OP_RESET, OP_VID_ON, OP_VID_OFF, OP_UNPROT_WR
  } op_t;

  // The enumeration order equals the level on address bits one and zero.
  typedef enum logic [1:0] {SEL_MAKER, SEL_PART, SEL_PROT, SEL_CONT} idsel_t;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int NUM_SECTORS = 19;
  localparam int SECT_W = 5;
  localparam int BIT_SIX = 6;

  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;

  // Unlock sequence for in-system identification and the reset command word.
  localparam logic [19:0] UNLOCK_ADDR0 = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h002aa;
  localparam logic [7:0] UNLOCK_DATA0 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'h55;
  localparam logic [7:0] AUTOSEL_CMD = 8'h90;
  localparam logic [7:0] RESET_CMD = 8'hf0;
  localparam logic [1:0] AUTOSEL_LAST_STEP = 2'h2;

  localparam int CLK_NS = 10;
  localparam int GLITCH_NS = 5;
  localparam int WR_PULSE_NS = 40;
  localparam int RD_ACCESS_NS = 90;
  localparam int PWRUP_NS = 1000;
  localparam int SYNC_LAT = 2;

  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

endpackage

// ==== src/pin_sync.sv ====
// Two-flop synchroniser for the flash data pins.
module pin_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinSync
);

  logic [7:0] meta_q;
  logic [7:0] sync_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  assign pinSync = sync_q;

endmodule // pin_sync

// ==== tb/flash_dev_model.sv ====
// Behavioural model of the flash command front as seen on the host pins.
module flash_dev_model #(
  parameter logic [7:0] MAKER = 8'h5c, // Arbitrary identification value.
  parameter logic [7:0] PART = 8'h2e, // Arbitrary identification value.
  parameter logic [7:0] CONT = 8'h61 // Arbitrary identification value.
) (
  input wire logic [19:0] addrPins,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [7:0] dataPinsOut,
  input wire logic vid9,
  // protection bits come from the bench; program and erase are not modelled.
  input wire logic [18:0] protIn,
  output logic [7:0] dataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] latA;
  time weFall = 0;
  logic [7:0] outQ = 8'h5a;
  logic [1:0] step = 2'h0;
  // reads the array until the unlock sequence is seen
  logic idQ = 1'b0;
  logic pwrOk = 1'b0;

  // Top boot sector map; only the sector index is modelled.
  function automatic logic [4:0] sect(logic [19:0] a);
    if (a[19:16] != 4'hf) return {1'b0, a[19:16]};
    if (!a[15]) return 5'd15;
    if (!a[14]) return a[13] ? 5'd17 : 5'd16;
    return 5'd18;
  endfunction

  function automatic logic [7:0] rd(logic [19:0] a);
    if (idQ || (vid9 && !a[6])) begin
      case (a[1:0])
        2'h0: return MAKER;
        2'h1: return PART;
        2'h2: return {7'h0, protIn[sect(a)]};
        default: return CONT;
      endcase
    end
    // no algorithm ever runs here, so other reads return array data.
    return a[7:0] ^ a[19:12];
  endfunction

  // no command until strobes have been seen idle
  always @(ceN or weN) if (ceN && weN) pwrOk = 1'b1;
  // address on the later falling edge
  always @(negedge weN or negedge ceN) if (!weN && !ceN && oeN) latA = addrPins;
  always @(negedge weN) weFall = $time;
  // data on the earlier rising edge, then decode
  always @(posedge weN or posedge ceN) begin
    if ((weN ^ ceN) && oeN && pwrOk && ($time - weFall >= flash_host_pkg::GLITCH_NS)) begin
      if (dataPinsOut == flash_host_pkg::RESET_CMD) begin
        idQ = 1'b0;
        step = 2'h0;
      end else if (step == 2'h0 && latA == flash_host_pkg::UNLOCK_ADDR0 && dataPinsOut == 8'haa) begin
        step = 2'h1;
      end else if (step == 2'h1 && latA == flash_host_pkg::UNLOCK_ADDR1 && dataPinsOut == 8'h55) begin
        step = 2'h2;
      end else if (step == 2'h2 && latA == flash_host_pkg::UNLOCK_ADDR0 && dataPinsOut == 8'h90) begin
        idQ = 1'b1;
        step = 2'h0;
      end else begin
        step = 2'h0;
      end
    end
  end
  // Released data pins show the inverse of the last value at each change of ceN, oeN, addrPins, vid9 or idQ, so every second change brings back the stale copy.
  always @(ceN or oeN or addrPins or idQ or vid9) outQ = (!ceN && !oeN) ? rd(addrPins) : ~outQ;
  assign dataOut = outQ;
endmodule // flash_dev_model

// ==== tb/flash_id_protect_cmd_front_tb.sv ====
// Self-checking testbench for the flash identification and protection host.
module flash_id_protect_cmd_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, cmdValid = 0, cmdHv = 0;
  logic [2:0] cmdOp = 0;
  logic [19:0] cmdAddr = 0, addrPins, a;
  logic [7:0] cmdData = 0, rspData, dataPinsOut, dataPinsIn;
  logic [1:0] cmdSel = 0;
  logic [4:0] cmdSector = 0;
  logic cmdReady, rspValid, rspErr, idMode, ceN, oeN, weN, dataPinsOe, addressBitNineVid, resetPinVid;
  logic [18:0] protMask, protIn = 0;
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'h3d77;
  localparam logic [7:0] MK = 8'h5c, PT = 8'h2e, CT = 8'h61; // Arbitrary identification values.
  always #5 clk_sys = ~clk_sys;

  flash_id_host DUT (.clk_sys, .rstn, .cmdValid, .cmdOp, .cmdAddr, .cmdData, .cmdSel, .cmdSector, .cmdHv,
    .cmdReady, .rspValid, .rspErr, .rspData, .idMode, .protMask, .addrPins, .ceN, .oeN, .weN,
    .dataPinsOut, .dataPinsOe, .dataPinsIn, .addressBitNineVid, .resetPinVid);
  flash_dev_model dev (.addrPins, .ceN, .oeN, .weN, .dataPinsOut, .vid9(addressBitNineVid), .protIn,
    .dataOut(dataPinsIn));

  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmd(flash_host_pkg::op_t op, logic [19:0] ad, logic [7:0] d = 0, logic [1:0] s = 0,
    logic [4:0] sc = 0, logic hv = 0);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1) @(negedge clk_sys);
    cmdValid = 1;
    cmdOp = op;
    cmdAddr = ad;
    cmdData = d;
    cmdSel = s;
    cmdSector = sc;
    cmdHv = hv;
    @(negedge clk_sys);
    cmdValid = 0;
    while (rspValid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) chk("rspValid", 1, 0);
  endtask

  function automatic logic [19:0] sa(int s);
    return s < 15 ? 20'(s) << 16 : s == 15 ? 20'hf0000 : s == 16 ? 20'hf8000 : s == 17 ? 20'hfa000 : 20'hfc000;
  endfunction

  function automatic logic [7:0] idx(logic [1:0] s, int sc);
    case (s)
      2'h0: return MK;
      2'h1: return PT;
      2'h2: return {7'h0, protIn[sc]};
      default: return CT;
    endcase
  endfunction

  // Every identification byte of every sector, by either method.
  task automatic sweep(logic hv);
    for (int s = 0; s < 19; s++) begin
      for (int k = 0; k < 4; k++) begin
        cmd(flash_host_pkg::OP_IDREAD, sa(s), 0, 2'(k), 5'(s), hv);
        chk("idByte", idx(2'(k), s), rspData);
      end
    end
  endtask

  task automatic rdchk;
    a = 20'($random(seed));
    cmd(flash_host_pkg::OP_READ, a);
    chk("read", a[7:0] ^ a[19:12], rspData);
  endtask

  // write strobe only with chip-enable low and output-enable high
  always @(negedge clk_sys) begin
    cyc++;
    if (rstn && weN === 1'b0 && (ceN !== 1'b0 || oeN !== 1'b1)) chk("writeStrobes", 3'b010, {ceN, oeN, weN});
    if (rstn && weN === 1'b0) chk("dataPinsOeWrite", 1, dataPinsOe);
    if (rstn && oeN === 1'b0) chk("dataPinsOeRead", 0, dataPinsOe);
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1;
    repeat (50) @(negedge clk_sys);
    chk("cmdReady", 0, cmdReady);
    chk("strobes", 3'b111, {ceN, oeN, weN});
    chk("protMask", 0, protMask);
    $display("test powerup done");
    repeat (8) rdchk;
    $display("test reads done");
    protIn = 19'($random(seed)) & ~19'h8;
    sweep(1);
    chk("protMask", protIn, protMask);
    $display("test hv id done");
    cmd(flash_host_pkg::OP_IDREAD, 0);
    chk("rspErr", 1, rspErr);
    cmd(flash_host_pkg::OP_WRITE, 20'h00555, 8'haa);
    cmd(flash_host_pkg::OP_WRITE, 20'h00123, 8'h00);
    rdchk;
    cmd(flash_host_pkg::OP_AUTOSEL, 0);
    @(negedge clk_sys);
    chk("idMode", 1, idMode);
    sweep(0);
    cmd(flash_host_pkg::OP_READ, 20'h00400);
    chk("rspErr", 1, rspErr);
    cmd(flash_host_pkg::OP_RESET, 20'h4c3a1);
    @(negedge clk_sys);
    chk("idMode", 0, idMode);
    rdchk;
    $display("test in-system id done");
    cmd(flash_host_pkg::OP_VID_ON, 0);
    @(negedge clk_sys);
    chk("resetPinVid", 1, resetPinVid);
    cmd(flash_host_pkg::OP_UNPROT_WR, 20'h30000, 8'h60);
    chk("rspErr", 1, rspErr);
    cmd(flash_host_pkg::OP_VID_OFF, 0);
    protIn = '1;
    sweep(1);
    cmd(flash_host_pkg::OP_UNPROT_WR, 20'h30000, 8'h60);
    chk("rspErr", 1, rspErr);
    cmd(flash_host_pkg::OP_VID_ON, 0);
    cmd(flash_host_pkg::OP_UNPROT_WR, 20'h30000, 8'h60);
    chk("rspErr", 0, rspErr);
    cmd(flash_host_pkg::OP_VID_OFF, 0);
    @(negedge clk_sys);
    chk("resetPinVid", 0, resetPinVid);
    $display("test protection done");
    tally_and_finish;
  end
endmodule // flash_id_protect_cmd_front_tb
